// ===== phy_capture.sv
// Port drive expansion and USB / MIPI PHY takeover of fixed ports
`timescale 1ns/1ps
`default_nettype none
module phy_capture (
  // Application ports
  input wire pin_mux_pkg::port_bits_s app_o,
  input wire pin_mux_pkg::port_en_s app_drive,
  // PHYs
  input wire logic usb_en,
  input wire pin_mux_pkg::usb_bits_s usb_o,
  input wire pin_mux_pkg::usb_bits_s usb_oe,
  input wire logic mipi_en,
  input wire pin_mux_pkg::mipi_bits_s mipi_o,
  input wire pin_mux_pkg::mipi_bits_s mipi_oe,
  // Effective per-bit sources and bits left to the application
  output pin_mux_pkg::port_bits_s eff_o,
  output pin_mux_pkg::port_bits_s eff_oe,
  output pin_mux_pkg::port_bits_s avail
);
  always_comb
  begin
    eff_o = app_o;
    eff_oe = '0;
    avail = '1;
    // A whole port drives or samples; its enable sets every bit's path
    eff_oe.single = app_drive.single;
    for (int i = 0; i < pin_mux_pkg::QUAD_N * pin_mux_pkg::QUAD_W; i++)
      eff_oe.quad[i] = app_drive.quad[i / pin_mux_pkg::QUAD_W];
    for (int i = 0; i < pin_mux_pkg::OCT_N * pin_mux_pkg::OCT_W; i++)
      eff_oe.octet[i] = app_drive.octet[i / pin_mux_pkg::OCT_W];
    for (int i = 0; i < pin_mux_pkg::HALF_N * pin_mux_pkg::HALF_W; i++)
      eff_oe.halfword[i] = app_drive.halfword[i / pin_mux_pkg::HALF_W];
    eff_oe.word = {pin_mux_pkg::WORD_W{app_drive.word}};
    if (mipi_en)
    begin
      eff_o.octet[pin_mux_pkg::MIPI_OCT_BITS-1:0] = mipi_o.octet;
      eff_oe.octet[pin_mux_pkg::MIPI_OCT_BITS-1:0] = mipi_oe.octet;
      avail.octet[pin_mux_pkg::MIPI_OCT_BITS-1:0] = '0;
      for (int i = 0; i < pin_mux_pkg::MIPI_SGL_N; i++)
      begin
        eff_o.single[pin_mux_pkg::MIPI_SGL_IDX[i]] = mipi_o.single[i];
        eff_oe.single[pin_mux_pkg::MIPI_SGL_IDX[i]] = mipi_oe.single[i];
        avail.single[pin_mux_pkg::MIPI_SGL_IDX[i]] = 1'b0;
      end
    end
    // USB wins where both PHYs are on; quad ports are untouched
    if (usb_en)
    begin
      eff_o.octet[pin_mux_pkg::USB_OCT_BITS-1:0] = usb_o.octet;
      eff_oe.octet[pin_mux_pkg::USB_OCT_BITS-1:0] = usb_oe.octet;
      avail.octet[pin_mux_pkg::USB_OCT_BITS-1:0] = '0;
      for (int i = 0; i < pin_mux_pkg::USB_SGL_N; i++)
      begin
        eff_o.single[pin_mux_pkg::USB_SGL_IDX[i]] = usb_o.single[i];
        eff_oe.single[pin_mux_pkg::USB_SGL_IDX[i]] = usb_oe.single[i];
        avail.single[pin_mux_pkg::USB_SGL_IDX[i]] = 1'b0;
      end
    end
  end
endmodule : phy_capture
`default_nettype wire

// ===== pin_mux_pkg.sv
// Package: pin map, port layouts and edge function masks for the port pin mux
package pin_mux_pkg;
  localparam int NUM_TILES = 2;
  localparam int NUM_PINS = 64;
  localparam int NUM_WIDTHS = 5;
  localparam int NUM_EDGE = 3;
  localparam int SGL_N = 16;
  localparam int QUAD_N = 6;
  localparam int QUAD_W = 4;
  localparam int OCT_N = 4;
  localparam int OCT_W = 8;
  localparam int HALF_N = 2;
  localparam int HALF_W = 16;
  localparam int WORD_W = 32;
  // Candidate order at a pin, narrowest first; edge order, strongest first
  localparam int CAND_SGL = 0;
  localparam int CAND_QUAD = 1;
  localparam int CAND_OCT = 2;
  localparam int CAND_HALF = 3;
  localparam int CAND_WORD = 4;
  localparam int EDGE_LINK = 0;
  localparam int EDGE_LPDDR = 1;
  localparam int EDGE_PLL = 2;
  // Row groups of the per-tile pin table
  localparam int ROW_GRP_A = 2;
  localparam int ROW_SGL_C = 10;
  localparam int ROW_GRP_B = 14;
  localparam int ROW_SGL_G = 22;
  localparam int ROW_GRP_C = 26;
  localparam int ROW_SGL_K = 34;
  localparam int ROW_GRP_D = 36;
  localparam int ROW_WORD_LO = 44;
  localparam int SGL_BASE_C = 2;
  localparam int SGL_BASE_G = 6;
  localparam int SGL_BASE_K = 10;
  localparam int SGL_BASE_M = 12;
  localparam int SGL_D_BITS = 4;
  localparam int QUAD_BASE_A = 0;
  localparam int QUAD_BASE_B = 8;
  localparam int QUAD_BASE_C = 16;
  localparam int QUAD_LO_BITS = 2;
  localparam int QUAD_MID_END = 6;
  localparam int OCT_BASE_A = 0;
  localparam int OCT_BASE_B = 8;
  localparam int OCT_BASE_C = 16;
  localparam int OCT_BASE_D = 24;
  localparam int WORD_BASE_A = 20;
  localparam int WORD_BASE_B = 28;
  localparam int WORD_B_BITS = 4;
  // PHY capture
  localparam int USB_OCT_BITS = 16;
  localparam int USB_SGL_N = 6;
  localparam int MIPI_OCT_BITS = 8;
  localparam int MIPI_SGL_N = 3;
  localparam logic [3:0] USB_SGL_IDX [USB_SGL_N] = '{4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'ha};
  localparam logic [3:0] MIPI_SGL_IDX [MIPI_SGL_N] = '{4'h4, 4'h8, 4'he};
  // Pins claimed by each edge function when it is enabled
  localparam logic [63:0] LINK_PIN_MASK = 64'h0000_0000_003c_0000;
  localparam logic [63:0] LPDDR_PIN_MASK = 64'h0fff_f000_0000_0000;
  localparam logic [63:0] PLL_PIN_MASK = 64'h0000_0000_0000_0800;

  typedef struct packed {
    logic [SGL_N-1:0] single;
    logic [QUAD_N*QUAD_W-1:0] quad;
    logic [OCT_N*OCT_W-1:0] octet;
    logic [HALF_N*HALF_W-1:0] halfword;
    logic [WORD_W-1:0] word;
  } port_bits_s;

  typedef struct packed {
    logic [SGL_N-1:0] single;
    logic [QUAD_N-1:0] quad;
    logic [OCT_N-1:0] octet;
    logic [HALF_N-1:0] halfword;
    logic word;
  } port_en_s;

  typedef struct packed {
    logic [USB_OCT_BITS-1:0] octet;
    logic [USB_SGL_N-1:0] single;
  } usb_bits_s;

  typedef struct packed {
    logic [MIPI_OCT_BITS-1:0] octet;
    logic [MIPI_SGL_N-1:0] single;
  } mipi_bits_s;

  typedef struct packed {
    logic en;
    logic [NUM_PINS-1:0] o;
    logic [NUM_PINS-1:0] oe;
  } edge_s;

  typedef struct packed {
    logic has1;
    logic [3:0] b1;
    logic has4;
    logic [4:0] b4;
    logic has8;
    logic [4:0] b8;
    logic has16;
    logic [4:0] b16;
    logic has32;
    logic [4:0] b32;
  } pin_map_s;

  function automatic logic [4:0] quad_bit(input int qb, input int k);
    if (k < QUAD_LO_BITS)
      return 5'(qb + k);
    else if (k < QUAD_MID_END)
      return 5'(qb + k + QUAD_LO_BITS);
    else
      return 5'(qb + k - (QUAD_MID_END - QUAD_LO_BITS));
  endfunction : quad_bit

  // Octet and halfword bit indices coincide across the whole table
  function automatic pin_map_s grp(input int qb, input int ob, input int k);
    pin_map_s m;
    m = '0;
    m.has4 = 1'b1;
    m.b4 = quad_bit(qb, k);
    m.has8 = 1'b1;
    m.b8 = 5'(ob + k);
    m.has16 = 1'b1;
    m.b16 = 5'(ob + k);
    return m;
  endfunction : grp

  function automatic pin_map_s pin_map(input int row);
    pin_map_s m;
    m = '0;
    if (row < ROW_GRP_A)
      m = '{has1: 1'b1, b1: 4'(row), default: '0};
    else if (row < ROW_SGL_C)
    begin
      m = grp(QUAD_BASE_A, OCT_BASE_A, row - ROW_GRP_A);
      m.has32 = 1'b1;
      m.b32 = 5'(WORD_BASE_A + row - ROW_GRP_A);
    end
    else if (row < ROW_GRP_B)
      m = '{has1: 1'b1, b1: 4'(row - ROW_SGL_C + SGL_BASE_C), default: '0};
    else if (row < ROW_SGL_G)
    begin
      m = grp(QUAD_BASE_B, OCT_BASE_B, row - ROW_GRP_B);
      m.has32 = (row - ROW_GRP_B) < WORD_B_BITS;
      m.b32 = 5'(WORD_BASE_B + row - ROW_GRP_B);
    end
    else if (row < ROW_GRP_C)
      m = '{has1: 1'b1, b1: 4'(row - ROW_SGL_G + SGL_BASE_G), default: '0};
    else if (row < ROW_SGL_K)
      m = grp(QUAD_BASE_C, OCT_BASE_C, row - ROW_GRP_C);
    else if (row < ROW_GRP_D)
      m = '{has1: 1'b1, b1: 4'(row - ROW_SGL_K + SGL_BASE_K), default: '0};
    else if (row < ROW_WORD_LO)
    begin
      m = grp(QUAD_BASE_A, OCT_BASE_D, row - ROW_GRP_D);
      m.has4 = 1'b0;
      m.has1 = (row - ROW_GRP_D) < SGL_D_BITS;
      m.b1 = 4'(row - ROW_GRP_D + SGL_BASE_M);
    end
    else
      m = '{has32: 1'b1, b32: 5'(row - ROW_WORD_LO), default: '0};
    return m;
  endfunction : pin_map
endpackage : pin_mux_pkg

// ===== pin_partner.sv
// Pin-side model: the outside world seen at the pins of both tiles
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  // Device pin drivers
  input wire logic [1:0][63:0] pin_o,
  input wire logic [1:0][63:0] pin_oe,
  // Levels that outside parts put on released pins
  input wire logic [1:0][63:0] ext,
  // Levels the device samples
  output logic [1:0][63:0] pin_i
);
  // A driven pin reads back its own level and ignores ext, so no contention is modelled
  assign pin_i = (pin_o & pin_oe) | (ext & ~pin_oe);
endmodule : pin_partner
`default_nettype wire

// ===== pin_pick.sv
// Per-pin driver choice: narrowest driving port, then edge functions on top
`timescale 1ns/1ps
`default_nettype none
module pin_pick (
  // Port candidates, narrowest first
  input wire logic [pin_mux_pkg::NUM_WIDTHS-1:0] port_oe,
  input wire logic [pin_mux_pkg::NUM_WIDTHS-1:0] port_o,
  // Edge functions, strongest first
  input wire logic [pin_mux_pkg::NUM_EDGE-1:0] edge_claim,
  input wire logic [pin_mux_pkg::NUM_EDGE-1:0] edge_o,
  input wire logic [pin_mux_pkg::NUM_EDGE-1:0] edge_oe,
  // Pin driver
  output logic pin_o,
  output logic pin_oe
);
  always_comb
  begin
    pin_o = 1'b0;
    pin_oe = 1'b0;
    for (int i = pin_mux_pkg::NUM_WIDTHS - 1; i >= 0; i--)
      if (port_oe[i])
      begin
        pin_o = port_o[i];
        pin_oe = 1'b1;
      end
    // A claimed pin follows the edge function even while it does not drive
    for (int i = pin_mux_pkg::NUM_EDGE - 1; i >= 0; i--)
      if (edge_claim[i])
      begin
        pin_o = edge_o[i];
        pin_oe = edge_oe[i];
      end
  end
endmodule : pin_pick
`default_nettype wire

// ===== port_pin_priority_mux.sv
// Top: two-tile port to pin multiplexer with PHY capture and edge overrides
`timescale 1ns/1ps
`default_nettype none
module port_pin_priority_mux (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Application side of the ports, per tile
  input wire pin_mux_pkg::port_bits_s [pin_mux_pkg::NUM_TILES-1:0] app_o,
  input wire pin_mux_pkg::port_en_s [pin_mux_pkg::NUM_TILES-1:0] app_drive,
  output pin_mux_pkg::port_bits_s [pin_mux_pkg::NUM_TILES-1:0] app_i,
  // USB PHY, per tile
  input wire logic [pin_mux_pkg::NUM_TILES-1:0] usb_en,
  input wire pin_mux_pkg::usb_bits_s [pin_mux_pkg::NUM_TILES-1:0] usb_o,
  input wire pin_mux_pkg::usb_bits_s [pin_mux_pkg::NUM_TILES-1:0] usb_oe,
  output pin_mux_pkg::usb_bits_s [pin_mux_pkg::NUM_TILES-1:0] usb_i,
  // MIPI PHY, per tile
  input wire logic [pin_mux_pkg::NUM_TILES-1:0] mipi_en,
  input wire pin_mux_pkg::mipi_bits_s [pin_mux_pkg::NUM_TILES-1:0] mipi_o,
  input wire pin_mux_pkg::mipi_bits_s [pin_mux_pkg::NUM_TILES-1:0] mipi_oe,
  output pin_mux_pkg::mipi_bits_s [pin_mux_pkg::NUM_TILES-1:0] mipi_i,
  // Edge functions, per tile
  input wire pin_mux_pkg::edge_s [pin_mux_pkg::NUM_TILES-1:0] link_out,
  input wire pin_mux_pkg::edge_s [pin_mux_pkg::NUM_TILES-1:0] lpddr_out,
  input wire pin_mux_pkg::edge_s [pin_mux_pkg::NUM_TILES-1:0] pll_out,
  output logic [pin_mux_pkg::NUM_TILES-1:0][pin_mux_pkg::NUM_PINS-1:0] edge_i,
  // Pins
  input wire logic [pin_mux_pkg::NUM_TILES-1:0][pin_mux_pkg::NUM_PINS-1:0] pin_i,
  output logic [pin_mux_pkg::NUM_TILES-1:0][pin_mux_pkg::NUM_PINS-1:0] pin_o,
  output logic [pin_mux_pkg::NUM_TILES-1:0][pin_mux_pkg::NUM_PINS-1:0] pin_oe
);
  typedef logic [pin_mux_pkg::NUM_TILES-1:0][pin_mux_pkg::NUM_PINS-1:0] tile_pins_t;

  typedef struct packed {
    tile_pins_t pin_o;
    tile_pins_t pin_oe;
    pin_mux_pkg::port_bits_s [pin_mux_pkg::NUM_TILES-1:0] app_i;
    pin_mux_pkg::usb_bits_s [pin_mux_pkg::NUM_TILES-1:0] usb_i;
    pin_mux_pkg::mipi_bits_s [pin_mux_pkg::NUM_TILES-1:0] mipi_i;
    tile_pins_t edge_i;
  } state_s;

  state_s st_q;
  state_s st_d;
  pin_mux_pkg::port_bits_s [pin_mux_pkg::NUM_TILES-1:0] eff_o;
  pin_mux_pkg::port_bits_s [pin_mux_pkg::NUM_TILES-1:0] eff_oe;
  pin_mux_pkg::port_bits_s [pin_mux_pkg::NUM_TILES-1:0] avail;
  tile_pins_t pick_o;
  tile_pins_t pick_oe;

  // Each tile is a full copy built from the same pin table
  for (genvar t = 0; t < pin_mux_pkg::NUM_TILES; t++)
  begin : g_tile
    phy_capture u_cap (
      .app_o(app_o[t]),
      .app_drive(app_drive[t]),
      .usb_en(usb_en[t]),
      .usb_o(usb_o[t]),
      .usb_oe(usb_oe[t]),
      .mipi_en(mipi_en[t]),
      .mipi_o(mipi_o[t]),
      .mipi_oe(mipi_oe[t]),
      .eff_o(eff_o[t]),
      .eff_oe(eff_oe[t]),
      .avail(avail[t])
    );

    for (genvar r = 0; r < pin_mux_pkg::NUM_PINS; r++)
    begin : g_pin
      localparam pin_mux_pkg::pin_map_s M = pin_mux_pkg::pin_map(r);
      logic [pin_mux_pkg::NUM_WIDTHS-1:0] c_oe;
      logic [pin_mux_pkg::NUM_WIDTHS-1:0] c_o;
      logic [pin_mux_pkg::NUM_EDGE-1:0] e_claim;
      logic [pin_mux_pkg::NUM_EDGE-1:0] e_o;
      logic [pin_mux_pkg::NUM_EDGE-1:0] e_oe;

      assign c_oe[pin_mux_pkg::CAND_SGL] = M.has1 && eff_oe[t].single[M.b1];
      assign c_oe[pin_mux_pkg::CAND_QUAD] = M.has4 && eff_oe[t].quad[M.b4];
      assign c_oe[pin_mux_pkg::CAND_OCT] = M.has8 && eff_oe[t].octet[M.b8];
      assign c_oe[pin_mux_pkg::CAND_HALF] = M.has16 && eff_oe[t].halfword[M.b16];
      assign c_oe[pin_mux_pkg::CAND_WORD] = M.has32 && eff_oe[t].word[M.b32];
      assign c_o[pin_mux_pkg::CAND_SGL] = eff_o[t].single[M.b1];
      assign c_o[pin_mux_pkg::CAND_QUAD] = eff_o[t].quad[M.b4];
      assign c_o[pin_mux_pkg::CAND_OCT] = eff_o[t].octet[M.b8];
      assign c_o[pin_mux_pkg::CAND_HALF] = eff_o[t].halfword[M.b16];
      assign c_o[pin_mux_pkg::CAND_WORD] = eff_o[t].word[M.b32];

      assign e_claim[pin_mux_pkg::EDGE_LINK] =
        link_out[t].en && pin_mux_pkg::LINK_PIN_MASK[r];
      assign e_claim[pin_mux_pkg::EDGE_LPDDR] =
        lpddr_out[t].en && pin_mux_pkg::LPDDR_PIN_MASK[r];
      assign e_claim[pin_mux_pkg::EDGE_PLL] =
        pll_out[t].en && pin_mux_pkg::PLL_PIN_MASK[r];
      assign e_o = {pll_out[t].o[r], lpddr_out[t].o[r], link_out[t].o[r]};
      assign e_oe = {pll_out[t].oe[r], lpddr_out[t].oe[r], link_out[t].oe[r]};

      pin_pick u_pick (
        .port_oe(c_oe),
        .port_o(c_o),
        .edge_claim(e_claim),
        .edge_o(e_o),
        .edge_oe(e_oe),
        .pin_o(pick_o[t][r]),
        .pin_oe(pick_oe[t][r])
      );
    end
  end

  always_comb
  begin
    pin_mux_pkg::port_bits_s fan;
    pin_mux_pkg::pin_map_s m;
    fan = '0;
    m = '0;
    st_d = st_q;
    for (int t = 0; t < pin_mux_pkg::NUM_TILES; t++)
    begin
      fan = '0;
      // Input has no precedence: every mapped bit sees the pin
      for (int r = 0; r < pin_mux_pkg::NUM_PINS; r++)
      begin
        m = pin_mux_pkg::pin_map(r);
        if (m.has1)
          fan.single[m.b1] = pin_i[t][r];
        if (m.has4)
          fan.quad[m.b4] = pin_i[t][r];
        if (m.has8)
          fan.octet[m.b8] = pin_i[t][r];
        if (m.has16)
          fan.halfword[m.b16] = pin_i[t][r];
        if (m.has32)
          fan.word[m.b32] = pin_i[t][r];
      end
      // Captured bits read zero so software cannot misread PHY traffic
      st_d.app_i[t] = fan & avail[t];
      st_d.usb_i[t].octet = fan.octet[pin_mux_pkg::USB_OCT_BITS-1:0];
      for (int i = 0; i < pin_mux_pkg::USB_SGL_N; i++)
        st_d.usb_i[t].single[i] = fan.single[pin_mux_pkg::USB_SGL_IDX[i]];
      st_d.mipi_i[t].octet = fan.octet[pin_mux_pkg::MIPI_OCT_BITS-1:0];
      for (int i = 0; i < pin_mux_pkg::MIPI_SGL_N; i++)
        st_d.mipi_i[t].single[i] = fan.single[pin_mux_pkg::MIPI_SGL_IDX[i]];
      st_d.edge_i[t] = pin_i[t];
      st_d.pin_o[t] = pick_o[t];
      st_d.pin_oe[t] = pick_oe[t];
    end
    if (rst)
      st_d = '0;
  end

  always_ff @(posedge clk)
  begin
    st_q <= st_d;
  end

  assign pin_o = st_q.pin_o;
  assign pin_oe = st_q.pin_oe;
  assign app_i = st_q.app_i;
  assign usb_i = st_q.usb_i;
  assign mipi_i = st_q.mipi_i;
  assign edge_i = st_q.edge_i;

  // Checks on tile 0, tile 1 also in shared_pin_a and tile_copy_a, with all edge functions and PHYs quiet unless stated
  logic edge_quiet;
  logic quiet;
  assign edge_quiet = !link_out[0].en && !lpddr_out[0].en && !pll_out[0].en;
  assign quiet = edge_quiet && !usb_en[0] && !mipi_en[0];

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  quad_over_word_a: assert property (
    (app_drive[0].quad[0] && quiet)
    |=> (pin_o[0][2] == $past(app_o[0].quad[0])) && pin_oe[0][2])
    else $error("Quad port did not win over wider ports");

  octet_over_half_a: assert property (
    (app_drive[0].octet[0] && app_drive[0].halfword[0] && app_drive[0].quad[1:0] == 2'h0
      && quiet)
    |=> (pin_o[0][9:2] == $past(app_o[0].octet[7:0])) && (&pin_oe[0][9:2]))
    else $error("Halfword bits reached pins under a driving octet port");

  quad_over_half_a: assert property (
    (app_drive[0].quad[3] && app_drive[0].halfword[0] && quiet)
    |=> pin_o[0][19:16] == $past(app_o[0].quad[15:12]))
    else $error("Halfword bits 10 to 13 not blocked by quad port");

  half_remaining_a: assert property (
    (app_drive[0].halfword[0] && app_drive[0].octet[1:0] == 2'h1
      && app_drive[0].quad[3:2] == 2'h2 && app_drive[0].word == 1'b0
      && app_drive[0].single == '0 && quiet)
    |=> (pin_o[0][15:14] == $past(app_o[0].halfword[9:8]))
      && (pin_o[0][21:20] == $past(app_o[0].halfword[15:14]))
      && (&pin_oe[0][21:14]) && (&pin_oe[0][9:2]))
    else $error("Halfword output outside its four free pins");

  input_fanout_a: assert property (
    (!usb_en[0] && !mipi_en[0])
    |=> (app_i[0].quad[7] == $past(pin_i[0][7]))
      && (app_i[0].octet[5] == $past(pin_i[0][7]))
      && (app_i[0].halfword[5] == $past(pin_i[0][7])))
    else $error("Pin value not presented to all mapped bits");

  shared_pin_a: assert property (
    1'b1 |=> (app_i[0].word[25] == $past(pin_i[0][7]))
      && (app_i[1].quad[7] == $past(pin_i[1][7])))
    else $error("Shared pin seven not fanned out");

  port_enable_a: assert property (
    (app_drive[0].octet[1] && app_drive[0].quad[3:2] == 2'h0 && quiet)
    |=> (&pin_oe[0][21:14]) && (pin_o[0][21:14] == $past(app_o[0].octet[15:8])))
    else $error("Enabled port did not set its pin paths");

  edge_override_a: assert property (
    link_out[0].en
    |=> ((pin_o[0] & pin_mux_pkg::LINK_PIN_MASK)
        == ($past(link_out[0].o) & pin_mux_pkg::LINK_PIN_MASK))
      && ((pin_oe[0] & pin_mux_pkg::LINK_PIN_MASK)
        == ($past(link_out[0].oe) & pin_mux_pkg::LINK_PIN_MASK)))
    else $error("Link did not override ports on its pins");

  usb_capture_a: assert property (
    usb_en[0]
    |=> (app_i[0].octet[15:0] == 16'h0000) && (app_i[0].single[4] == 1'b0)
      && (pin_o[0][12] == $past(usb_o[0].single[0]))
      && (pin_oe[0][12] == $past(usb_oe[0].single[0])))
    else $error("USB PHY did not take its ports");

  quad_bypass_a: assert property (
    (usb_en[0] && app_drive[0].quad[0] && edge_quiet)
    |=> (pin_o[0][3:2] == $past(app_o[0].quad[1:0]))
      && (pin_o[0][9:8] == $past(app_o[0].quad[3:2])) && pin_oe[0][9])
    else $error("Quad port lost its pins to the USB PHY");

  mipi_capture_a: assert property (
    mipi_en[0]
    |=> (app_i[0].octet[7:0] == 8'h00) && (app_i[0].single[14] == 1'b0)
      && (mipi_i[0].single[2] == $past(pin_i[0][38])))
    else $error("MIPI PHY did not take its ports");

  phy_off_map_a: assert property (
    (app_drive[0].single[4] && quiet)
    |=> (pin_o[0][12] == $past(app_o[0].single[4])) && pin_oe[0][12]
      && (app_i[0].single[4] == $past(pin_i[0][12])))
    else $error("Port not mapped normally with PHYs off");

  tile_copy_a: assert property (
    (app_drive[0] == app_drive[1] && app_o[0] == app_o[1] && quiet
      && !usb_en[1] && !mipi_en[1] && !link_out[1].en && !lpddr_out[1].en
      && !pll_out[1].en)
    |=> (pin_o[0] == pin_o[1]) && (pin_oe[0] == pin_oe[1]))
    else $error("Tiles map pins differently");

  idle_driver_off_a: assert property (
    (app_drive[0] == '0 && quiet)
    |=> pin_oe[0] == '0)
    else $error("Pin driven with no enabled source");

  quad_drive_oe_a: assert property (
    (app_drive[0].quad[3] && quiet)
    |=> &pin_oe[0][19:16])
    else $error("Quad port did not drive its pins");

  word_fanout_a: assert property (
    1'b1 |=> app_i[0].word[19:0] == $past(pin_i[0][63:44]))
    else $error("Upper pins not fanned to word port");

  lpddr_override_a: assert property (
    lpddr_out[0].en
    |=> ((pin_o[0] & pin_mux_pkg::LPDDR_PIN_MASK)
        == ($past(lpddr_out[0].o) & pin_mux_pkg::LPDDR_PIN_MASK))
      && ((pin_oe[0] & pin_mux_pkg::LPDDR_PIN_MASK)
        == ($past(lpddr_out[0].oe) & pin_mux_pkg::LPDDR_PIN_MASK)))
    else $error("LPDDR did not override ports on its pins");

  pll_override_a: assert property (
    pll_out[0].en
    |=> ((pin_o[0] & pin_mux_pkg::PLL_PIN_MASK)
        == ($past(pll_out[0].o) & pin_mux_pkg::PLL_PIN_MASK))
      && ((pin_oe[0] & pin_mux_pkg::PLL_PIN_MASK)
        == ($past(pll_out[0].oe) & pin_mux_pkg::PLL_PIN_MASK)))
    else $error("PLL did not override ports on its pins");

  usb_input_a: assert property (
    usb_en[0]
    |=> (usb_i[0].octet[15:8] == $past(pin_i[0][21:14]))
      && (usb_i[0].octet[7:0] == $past(pin_i[0][9:2]))
      && (usb_i[0].single[5] == $past(pin_i[0][34]))
      && (usb_i[0].single[4:2] == $past(pin_i[0][25:23]))
      && (usb_i[0].single[1:0] == $past(pin_i[0][13:12])))
    else $error("USB PHY input not taken from its pins");

  phy_release_a: assert property (
    (!usb_en[0] && !mipi_en[0])
    |=> (app_i[0].octet[15:8] == $past(pin_i[0][21:14]))
      && (app_i[0].single[10] == $past(pin_i[0][34])))
    else $error("Port input held back with PHYs off");
endmodule : port_pin_priority_mux
`default_nettype wire

// ===== tb.sv
// Testbench: pin priority, edge overrides, input fan-out and PHY capture
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  pin_mux_pkg::port_bits_s [1:0] app_o = '0;
  pin_mux_pkg::port_en_s [1:0] app_drive = '0;
  pin_mux_pkg::port_bits_s [1:0] app_i;
  logic [1:0] usb_en = '0;
  pin_mux_pkg::usb_bits_s [1:0] usb_o = '0;
  pin_mux_pkg::usb_bits_s [1:0] usb_oe = '0;
  pin_mux_pkg::usb_bits_s [1:0] usb_i;
  logic [1:0] mipi_en = '0;
  pin_mux_pkg::mipi_bits_s [1:0] mipi_o = '0;
  pin_mux_pkg::mipi_bits_s [1:0] mipi_oe = '0;
  pin_mux_pkg::mipi_bits_s [1:0] mipi_i;
  pin_mux_pkg::edge_s [1:0] lnk = '0;
  pin_mux_pkg::edge_s [1:0] ddr = '0;
  pin_mux_pkg::edge_s [1:0] pll = '0;
  logic [1:0][63:0] edge_i;
  logic [1:0][63:0] pin_i;
  logic [1:0][63:0] pin_o;
  logic [1:0][63:0] pin_oe;
  logic [1:0][63:0] ext = '0;
  int err_count = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  port_pin_priority_mux dut_u (.clk(clk), .rst(rst), .app_o(app_o), .app_drive(app_drive),
    .app_i(app_i), .usb_en(usb_en), .usb_o(usb_o), .usb_oe(usb_oe), .usb_i(usb_i),
    .mipi_en(mipi_en), .mipi_o(mipi_o), .mipi_oe(mipi_oe), .mipi_i(mipi_i),
    .link_out(lnk), .lpddr_out(ddr), .pll_out(pll), .edge_i(edge_i),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
  pin_partner far_u (.pin_o(pin_o), .pin_oe(pin_oe), .ext(ext), .pin_i(pin_i));
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // Inputs move at the falling edge; outputs are read one rising edge later
  task automatic step();
    @(posedge clk);
    @(negedge clk);
  endtask : step
  function automatic logic [63:0] rnd64();
    return {$urandom, $urandom};
  endfunction : rnd64
  // Octet A, quad D, halfword A and word all driving
  function automatic logic [63:0] exp_a(input pin_mux_pkg::port_bits_s a);
    logic [63:0] e;
    e = '0;
    e[9:2] = a.octet[7:0];
    e[15:14] = a.halfword[9:8];
    e[19:16] = a.quad[15:12];
    e[21:20] = a.halfword[15:14];
    e[63:44] = a.word[19:0];
    return e;
  endfunction : exp_a
  function automatic logic [63:0] ovr(input logic [63:0] b, l, d, p);
    return (b & ~(pin_mux_pkg::LINK_PIN_MASK | pin_mux_pkg::LPDDR_PIN_MASK
      | pin_mux_pkg::PLL_PIN_MASK)) | (l & pin_mux_pkg::LINK_PIN_MASK)
      | (d & pin_mux_pkg::LPDDR_PIN_MASK) | (p & pin_mux_pkg::PLL_PIN_MASK);
  endfunction : ovr
  initial
  begin
    #200us;
    err_count++;
    end_sim();
  end
  initial
  begin
    logic [159:0] rv;
    pin_mux_pkg::port_bits_s r;
    logic [63:0] bo;
    void'($urandom(7956));
    repeat (5) @(negedge clk);
    chk("oe in reset", pin_oe[0] | pin_oe[1], '0);
    rst = 1'b0;
    step();
    chk("idle oe", pin_oe[0] | pin_oe[1], '0);
    for (int t = 0; t < 2; t++)
    begin
      repeat (3)
      begin
        rv = {$urandom, $urandom, $urandom, $urandom, $urandom};
        r = rv[135:0];
        app_o[t] = r;
        app_drive[t] = '0;
        app_drive[t].octet[0] = 1'b1;
        app_drive[t].quad[3] = 1'b1;
        app_drive[t].halfword[0] = 1'b1;
        app_drive[t].word = 1'b1;
        bo = 64'hffff_f000_003f_c3fc;
        step();
        chk("oe prio", pin_oe[t], bo);
        chk("octet rows", pin_o[t] & 64'h3fc, exp_a(r) & 64'h3fc);
        chk("quad d rows", pin_o[t] & 64'hf_0000, exp_a(r) & 64'hf_0000);
        chk("half rows", pin_o[t] & 64'h30_c000, exp_a(r) & 64'h30_c000);
        chk("word rows", pin_o[t] & bo, exp_a(r));
        chk("other tile", pin_oe[1-t], '0);
        lnk[t] = {1'b1, rnd64(), rnd64()};
        ddr[t] = {1'b1, rnd64(), rnd64()};
        pll[t] = {1'b1, rnd64(), rnd64()};
        step();
        chk("edge oe", pin_oe[t], ovr(bo, lnk[t].oe, ddr[t].oe, pll[t].oe));
        chk("edge o", pin_o[t] & pin_oe[t], ovr(exp_a(r), lnk[t].o & lnk[t].oe,
          ddr[t].o & ddr[t].oe, pll[t].o & pll[t].oe));
        lnk[t] = '0;
        ddr[t] = '0;
        pll[t] = '0;
        // Whole ports released together, never half driven
        app_drive[t] = '0;
        ext[t] = rnd64();
        step();
        step();
        chk("row 7 fan", {app_i[t].quad[7], app_i[t].octet[5], app_i[t].halfword[5],
          app_i[t].word[25]}, {4{ext[t][7]}});
        chk("fan lo", {app_i[t].octet[7:0], app_i[t].halfword[7:0]},
          {2{ext[t][9:2]}});
        chk("fan word", app_i[t].word[19:0], ext[t][63:44]);
        chk("edge in", edge_i[t], ext[t]);
      end
      app_drive[t].octet = 4'h3;
      app_drive[t].single = 16'h07b0;
      usb_en[t] = 1'b1;
      usb_o[t] = 22'($urandom);
      usb_oe[t] = '1;
      step();
      chk("usb oct", {pin_o[t][21:14], pin_o[t][9:2]}, usb_o[t].octet);
      chk("usb sgl", {pin_o[t][34], pin_o[t][25:23], pin_o[t][13:12]},
        usb_o[t].single);
      app_drive[t].quad[0] = 1'b1;
      step();
      chk("quad a usb", {pin_o[t][9:8], pin_o[t][3:2]}, r.quad[3:0]);
      chk("usb in", usb_i[t], usb_o[t]);
      usb_en[t] = 1'b0;
      step();
      chk("usb off oct", pin_o[t][7:4], r.octet[5:2]);
      chk("usb off sgl", pin_o[t][13:12], r.single[5:4]);
      app_drive[t].quad[0] = 1'b0;
      mipi_en[t] = 1'b1;
      mipi_o[t] = 11'($urandom);
      mipi_oe[t] = '1;
      step();
      chk("mipi", {pin_o[t][9:2], pin_o[t][38], pin_o[t][24], pin_o[t][12]},
        mipi_o[t]);
      mipi_en[t] = 1'b0;
      app_drive[t] = '0;
      step();
      chk("mipi in", mipi_i[t], mipi_o[t]);
    end
    // Same drive on both tiles, word port left off
    app_o = {r, r};
    app_drive[0].octet[0] = 1'b1;
    app_drive[0].quad[3] = 1'b1;
    app_drive[0].halfword[0] = 1'b1;
    app_drive[1] = app_drive[0];
    step();
    for (int t = 0; t < 2; t++)
    begin
      chk("tile oe", pin_oe[t], 64'h3f_c3fc);
      chk("tile o", pin_o[t] & 64'h3f_c3fc, exp_a(r) & 64'h3f_c3fc);
    end
    end_sim();
  end
endmodule : tb
`default_nettype wire
